// ==== src/iwd_pkg.sv ====
// Purpose: Shared constants and types for the integer word divider
// Assumes: 32-bit APB data path, one aligned word per register
// Notes: Register offsets are byte addresses
package iwd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] IWD_OFS_DIVIDEND = 8'h00;
  localparam logic [7:0] IWD_OFS_DIVISOR = 8'h04;
  localparam logic [7:0] IWD_OFS_CONTROL = 8'h08;
  localparam logic [7:0] IWD_OFS_QUOTIENT = 8'h0c;
  localparam logic [7:0] IWD_OFS_FLAGS = 8'h10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int IWD_CTL_GO = 0;
  localparam int IWD_CTL_SIGNED = 1;
  localparam int IWD_CTL_RECORD = 2;
  localparam int IWD_CTL_OE = 3;
  localparam int IWD_CTL_BUSY = 4;
  localparam int IWD_FLG_CR_LSB = 0;
  localparam int IWD_FLG_BUSY = 4;
  localparam int IWD_FLG_OV = 8;
  localparam int IWD_FLG_SO = 9;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [31:0] IWD_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] IWD_MOST_NEG = 32'h8000_0000;
  localparam logic [31:0] IWD_MINUS_ONE = 32'hffff_ffff;
  localparam logic [5:0] IWD_ITER_CNT = 6'h20;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic oe;
    logic record_bit;
    logic sgn;
  } iwd_op_t;

  typedef struct packed {
    logic less_than_bit;
    logic greater_than_bit;
    logic equal_bit;
    logic so;
  } iwd_cr_t;

  typedef enum logic [1:0] {IWD_IDLE, IWD_RUN, IWD_FIN} iwd_state_t;

  // Magnitude of a two's-complement word
  function automatic logic [31:0] iwd_abs(input logic [31:0] v);
    iwd_abs = v[31] ? 32'(~v + 32'h1) : v;
  endfunction

endpackage

// ==== src/iwd_divcore.sv ====
// Purpose: Unsigned restoring divider, one quotient bit per cycle
// Assumes: Operands are held by the caller only for the start cycle
// Notes: Remainder is kept internally and not exported
`timescale 1ns/1ns
`default_nettype none
module iwd_divcore
  import iwd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  output logic done,
  output logic [31:0] quot
);

  logic [31:0] rem_r;
  logic [31:0] dvs_r;
  logic [5:0] cnt_r;
  logic [32:0] shifted;
  logic [32:0] diff;

  // Trial subtraction of the shifted partial remainder
  assign shifted = {rem_r, quot[31]};
  assign diff = shifted - {1'b0, dvs_r};

  // Iteration datapath
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rem_r <= IWD_RST_WORD;
      dvs_r <= IWD_RST_WORD;
      quot <= IWD_RST_WORD;
      cnt_r <= 6'h00;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        rem_r <= IWD_RST_WORD;
        dvs_r <= divisor;
        quot <= dividend;
        cnt_r <= IWD_ITER_CNT;
      end else if (cnt_r != 6'h00) begin
        if (!diff[32]) begin
          rem_r <= diff[31:0];
          quot <= {quot[30:0], 1'b1};
        end else begin
          rem_r <= shifted[31:0];
          quot <= {quot[30:0], 1'b0};
        end
        cnt_r <= 6'(cnt_r - 6'h01);
        done <= (cnt_r == 6'h01);
      end
    end
  end

endmodule
`default_nettype wire

// ==== src/iwd_flagcalc.sv ====
// Purpose: Condition field and overflow flag next-value logic
// Assumes: upd is high for exactly one cycle per finished divide that has overflow-enable set
// Notes: Hardware set beats a software write in the same cycle
`timescale 1ns/1ns
`default_nettype none
module iwd_flagcalc
  import iwd_pkg::*;
(
  input wire logic [31:0] quot,
  input wire logic upd,
  input wire logic ovf,
  input wire logic so_cur,
  input wire logic ov_cur,
  input wire logic wr_en,
  input wire logic wr_so,
  input wire logic wr_ov,
  output iwd_cr_t cr,
  output logic so_nxt,
  output logic ov_nxt
);

  // Overflow flags; software write only when hardware is silent
  always_comb begin
    ov_nxt = ov_cur;
    so_nxt = so_cur;
    if (upd) begin
      ov_nxt = ovf;
    end else if (wr_en) begin
      ov_nxt = wr_ov;
    end
    if (upd && ovf) begin
      so_nxt = 1'b1;
    end else if (wr_en) begin
      so_nxt = wr_so;
    end
  end

  // Signed compare of the quotient against zero
  always_comb begin
    cr.less_than_bit = quot[31];
    cr.greater_than_bit = !quot[31] && (quot != IWD_RST_WORD);
    cr.equal_bit = (quot == IWD_RST_WORD);
    cr.so = so_nxt;
  end

endmodule
`default_nettype wire

// ==== src/iwd_top.sv ====
// Purpose: APB-controlled 32-bit signed and unsigned word divider
// Assumes: Single clock domain, APB master per AMBA rules
// Notes: Undefined results are given as a zero quotient
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module iwd_top
  import iwd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic div_done,
  output iwd_cr_t condition_field_zero,
  output logic overflow_flag,
  output logic summary_overflow
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  iwd_state_t state_r;
  iwd_op_t op_r;
  logic [31:0] dividend_source_r;
  logic [31:0] divisor_source_r;
  logic [31:0] quot_r;
  logic ovf_r;
  logic neg_r;
  logic acc_wr;
  logic acc_rd;
  logic go_acc;
  logic flag_wr;
  logic ovf_nxt;
  logic core_start;
  logic core_done;
  logic [31:0] core_quot;
  logic [31:0] core_dvd;
  logic [31:0] core_dvs;
  logic fin;
  iwd_cr_t cr_nxt;
  logic so_nxt;
  logic ov_nxt;
  logic [31:0] rd_word;
  logic busy;

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // Access completes on the cycle where pready is seen high
  assign acc_wr = psel && penable && pready && pwrite;
  assign acc_rd = psel && penable && !pready && !pwrite;
  assign busy = (state_r != IWD_IDLE);
  assign go_acc = acc_wr && (paddr == IWD_OFS_CONTROL) &&
                  pwdata[IWD_CTL_GO] && !busy;
  assign flag_wr = acc_wr && (paddr == IWD_OFS_FLAGS);

  // One wait state keeps every bus output a flop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
    end
  end

  // Read mux, unmapped addresses give zero
  always_comb begin
    rd_word = IWD_RST_WORD;
    if (paddr == IWD_OFS_DIVIDEND) begin
      rd_word = dividend_source_r;
    end else if (paddr == IWD_OFS_DIVISOR) begin
      rd_word = divisor_source_r;
    end else if (paddr == IWD_OFS_CONTROL) begin
      rd_word[IWD_CTL_SIGNED] = op_r.sgn;
      rd_word[IWD_CTL_RECORD] = op_r.record_bit;
      rd_word[IWD_CTL_OE] = op_r.oe;
      rd_word[IWD_CTL_BUSY] = busy;
    end else if (paddr == IWD_OFS_QUOTIENT) begin
      rd_word = quot_r;
    end else if (paddr == IWD_OFS_FLAGS) begin
      rd_word[IWD_FLG_CR_LSB+3:IWD_FLG_CR_LSB] = condition_field_zero;
      rd_word[IWD_FLG_BUSY] = busy;
      rd_word[IWD_FLG_OV] = overflow_flag;
      rd_word[IWD_FLG_SO] = summary_overflow;
    end
  end

  // Read data and error answer, taken when pready rises
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= IWD_RST_WORD;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        prdata <= acc_rd ? rd_word : IWD_RST_WORD;
        pslverr <= (paddr != IWD_OFS_DIVIDEND) &&
                   (paddr != IWD_OFS_DIVISOR) &&
                   (paddr != IWD_OFS_CONTROL) &&
                   (paddr != IWD_OFS_QUOTIENT) &&
                   (paddr != IWD_OFS_FLAGS);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // operands frozen while busy
  // Writes during a divide are dropped so inputs cannot shift
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dividend_source_r <= IWD_RST_WORD;
      divisor_source_r <= IWD_RST_WORD;
    end else if (ce && acc_wr && !busy) begin
      if (paddr == IWD_OFS_DIVIDEND) begin
        dividend_source_r <= pwdata;
      end else if (paddr == IWD_OFS_DIVISOR) begin
        divisor_source_r <= pwdata;
      end
    end
  end

  // ****************************************************************
  // Control sequence
  // ****************************************************************

  assign ovf_nxt = (divisor_source_r == IWD_RST_WORD) ||
                   (pwdata[IWD_CTL_SIGNED] &&
                    dividend_source_r == IWD_MOST_NEG &&
                    divisor_source_r == IWD_MINUS_ONE);

  assign core_dvd = pwdata[IWD_CTL_SIGNED] ?
                    iwd_abs(dividend_source_r) : dividend_source_r;
  assign core_dvs = pwdata[IWD_CTL_SIGNED] ?
                    iwd_abs(divisor_source_r) : divisor_source_r;
  assign core_start = go_acc && !ovf_nxt;
  assign fin = ce && (state_r == IWD_FIN);

  // Operation latch on a start
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_r <= '0;
      ovf_r <= 1'b0;
      neg_r <= 1'b0;
    end else if (ce && go_acc) begin
      op_r.sgn <= pwdata[IWD_CTL_SIGNED];
      op_r.record_bit <= pwdata[IWD_CTL_RECORD];
      op_r.oe <= pwdata[IWD_CTL_OE];
      ovf_r <= ovf_nxt;
      neg_r <= pwdata[IWD_CTL_SIGNED] &&
               (dividend_source_r[31] ^ divisor_source_r[31]);
    end
  end

  // Sequencer; an undefined divide skips the iterations
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= IWD_IDLE;
    end else if (ce) begin
      case (state_r)
        IWD_IDLE: begin
          if (go_acc) begin
            state_r <= ovf_nxt ? IWD_FIN : IWD_RUN;
          end
        end
        IWD_RUN: begin
          if (core_done) begin
            state_r <= IWD_FIN;
          end
        end
        default: begin
          state_r <= IWD_IDLE;
        end
      endcase
    end
  end

  // sign restore gives truncation toward zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quot_r <= IWD_RST_WORD;
    end else if (ce) begin
      if (go_acc && ovf_nxt) begin
        quot_r <= IWD_RST_WORD;
      end else if (state_r == IWD_RUN && core_done) begin
        quot_r <= neg_r ? 32'(~core_quot + 32'h1) : core_quot;
      end
    end
  end

  iwd_divcore u_core (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .start(core_start),
    .dividend(core_dvd),
    .divisor(core_dvs),
    .done(core_done),
    .quot(core_quot)
  );

  // ****************************************************************
  // Flags and completion
  // ****************************************************************
  iwd_flagcalc u_flags (
    .quot(quot_r),
    .upd(fin && op_r.oe),
    .ovf(ovf_r),
    .so_cur(summary_overflow),
    .ov_cur(overflow_flag),
    .wr_en(ce && flag_wr),
    .wr_so(pwdata[IWD_FLG_SO]),
    .wr_ov(pwdata[IWD_FLG_OV]),
    .cr(cr_nxt),
    .so_nxt(so_nxt),
    .ov_nxt(ov_nxt)
  );

  // sticky summary, set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overflow_flag <= 1'b0;
      summary_overflow <= 1'b0;
    end else if (ce) begin
      overflow_flag <= ov_nxt;
      summary_overflow <= so_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      condition_field_zero <= '0;
    end else if (fin && op_r.record_bit) begin
      condition_field_zero <= cr_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_done <= 1'b0;
    end else if (ce) begin
      div_done <= (state_r == IWD_FIN);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Reference arithmetic for the quotient checks, assertions only
  logic [63:0] chk_prod;
  logic [31:0] chk_srem;
  assign chk_prod = {32'h0, quot_r} * {32'h0, divisor_source_r};
  assign chk_srem = 32'(dividend_source_r - quot_r * divisor_source_r);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_done_bound: assert property (
    go_acc |-> ##[1:80] div_done)
    else $error("divide did not complete in time");
  a_done_single: assert property (
    div_done |=> !div_done)
    else $error("completion held longer than one cycle");
  a_ovf_sets: assert property (
    fin && op_r.oe && ovf_r |=> overflow_flag && summary_overflow)
    else $error("overflow not flagged on undefined divide");
  a_noe_keeps: assert property (
    fin && !op_r.oe && !flag_wr |=>
      $stable(overflow_flag) && $stable(summary_overflow))
    else $error("flags changed with overflow disabled");
  a_so_sticky: assert property (
    summary_overflow && !flag_wr |=> summary_overflow)
    else $error("summary overflow lost without a clear");
  a_ucheck_quot: assert property (
    fin && !ovf_r && !op_r.sgn |->
      chk_prod <= {32'h0, dividend_source_r} &&
      ({32'h0, dividend_source_r} - chk_prod) <
        {32'h0, divisor_source_r})
    else $error("unsigned quotient wrong");
  a_scheck_trunc: assert property (
    fin && !ovf_r && op_r.sgn |->
      (chk_srem == IWD_RST_WORD ||
       chk_srem[31] == dividend_source_r[31]) &&
      iwd_abs(chk_srem) < iwd_abs(divisor_source_r))
    else $error("signed quotient not truncated toward zero");
  a_cr_record: assert property (
    fin && op_r.record_bit |=>
      condition_field_zero.equal_bit == (quot_r == IWD_RST_WORD) &&
      condition_field_zero.less_than_bit == quot_r[31] &&
      condition_field_zero.greater_than_bit ==
        ($signed(quot_r) > 0))
    else $error("condition field does not match quotient");
  a_cr_norecord: assert property (
    fin && !op_r.record_bit |=> $stable(condition_field_zero))
    else $error("condition field changed without record");
  a_cr_sobit: assert property (
    fin && op_r.record_bit |=> condition_field_zero.so == summary_overflow)
    else $error("condition field summary bit out of step");
  a_ov_clears: assert property (
    fin && op_r.oe && !ovf_r |=> !overflow_flag)
    else $error("overflow flag not cleared on a clean divide");
  a_ops_frozen: assert property (
    busy |=> $stable(dividend_source_r) && $stable(divisor_source_r))
    else $error("operand changed while a divide was running");

  c_signed_div: cover property (fin && op_r.sgn && !ovf_r);
  c_unsigned_div: cover property (fin && !op_r.sgn && !ovf_r);
  c_overflow: cover property (fin && op_r.oe && ovf_r);
  c_set_vs_clear: cover property (fin && op_r.oe && ovf_r && flag_wr);
  c_record_unsigned: cover property (fin && op_r.record_bit && !op_r.sgn);

endmodule
`default_nettype wire

// ==== tb/iwd_issue_model.sv ====
// Purpose: Issue-side model that places requests on the divider's APB
// Assumes: One request at a time; req held high until done shows
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ns
`default_nettype none
module iwd_issue_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic done,
  output logic [31:0] rdata,
  output logic err
);
  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // operands held stable
  // Re-arm blocked while done shows, so a late req drop is harmless
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      done <= 1'b0;
      rdata <= 32'h0000_0000;
      err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr; // Stale values must not look valid
        pwdata <= ~pwdata;
        done <= 1'b1;
        rdata <= prdata;
        err <= pslverr;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (req && !done) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_integer_word_divider.sv ====
// Purpose: Self-checking bench for the integer word divider
// Assumes: Undefined divides read back a zero quotient
// Notes: Expected results are worked out here from the operands
`timescale 1ns/1ns
`default_nettype none
module test_integer_word_divider;
  import iwd_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic psel, penable, pwrite, pready, pslverr, div_done, done, err;
  logic overflow_flag, summary_overflow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, got;
  iwd_cr_t condition_field_zero;
  iwd_cr_t exp_cr = '0;
  logic exp_ov = 1'b0;
  logic exp_so = 1'b0;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int done_seen = 0;

  // ****************************************************************
  // Clock, design and issue model
  // ****************************************************************
  always #5 clk_sys = ~clk_sys;

  iwd_top iwd_top_inst (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .div_done(div_done),
    .condition_field_zero(condition_field_zero),
    .overflow_flag(overflow_flag), .summary_overflow(summary_overflow));

  iwd_issue_model iwd_issue_model_inst (.clk_sys(clk_sys), .rstn(rstn),
    .req(req), .wr(wr), .addr(addr), .wdata(wdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done),
    .rdata(rdata), .err(err));

  // Completion counter and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (div_done === 1'b1) done_seen <= done_seen + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // One APB transfer through the issue model; read data lands in got
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(negedge clk_sys);
    while (done !== 1'b1) @(negedge clk_sys);
    got = rdata;
    @(posedge clk_sys);
    req <= 1'b0;
  endtask

  // Control nibble: go, signed, record, overflow-enable
  task automatic div(input logic [31:0] a, input logic [31:0] b,
                     input logic [3:0] c);
    int n;
    int t;
    logic [31:0] q;
    logic undef;
    n = done_seen;
    undef = (b == 0) || (c[1] && a == IWD_MOST_NEG && b == IWD_MINUS_ONE);
    if (undef) q = 32'h0000_0000;
    else if (c[1]) q = $signed(a) / $signed(b);
    else q = a / b;
    if (c[3]) begin
      exp_ov = undef;
      exp_so = exp_so | undef;
    end
    if (c[2]) exp_cr = {$signed(q) < 0, $signed(q) > 0, q == 0, exp_so};
    apb(1'b1, IWD_OFS_DIVIDEND, a);
    apb(1'b1, IWD_OFS_DIVISOR, b);
    apb(1'b1, IWD_OFS_CONTROL, {28'h0, c});
    t = cycles;
    while (done_seen == n) @(negedge clk_sys);
    // Pulse is counted one edge after it shows: 34 plus 1, or 1 plus 1
    chk(32'(cycles - t), undef ? 32'h2 : 32'h23, "latency");
    chk({28'h0, condition_field_zero}, {28'h0, exp_cr}, "cr");
    chk({30'h0, overflow_flag, summary_overflow},
        {30'h0, exp_ov, exp_so}, "ov so");
    apb(1'b0, IWD_OFS_QUOTIENT, 32'h0);
    chk(got, q, "quotient");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_case();
    apb(1'b0, IWD_OFS_QUOTIENT, 32'h0);
    chk(got, IWD_RST_WORD, "quotient reset");
    chk({31'h0, err}, 32'h0, "mapped err");
    apb(1'b0, IWD_OFS_FLAGS, 32'h0);
    chk(got, IWD_RST_WORD, "flags reset");
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    chk(got, 32'h0000_0000, "unmapped data");
  endtask

  task automatic signed_cases();
    div(32'h0000_0007, 32'h0000_0002, 4'h7);
    div(32'hffff_fff9, 32'h0000_0002, 4'hf);
    div(32'h0000_0007, 32'hffff_fffe, 4'h3);
    div(32'hffff_fff9, 32'hffff_fffe, 4'h7);
    div(32'h0000_0000, 32'h0000_0005, 4'h7);
    div(IWD_MOST_NEG, IWD_MINUS_ONE, 4'hf);
    div(32'h0000_0005, 32'h0000_0000, 4'hb);
  endtask

  task automatic unsigned_cases();
    div(32'h0000_0009, 32'h0000_0002, 4'hd);
    div(32'hffff_fffe, 32'h0000_0001, 4'h5);
    div(32'hffff_ffff, 32'h0000_0010, 4'h1);
    div(IWD_MOST_NEG, IWD_MINUS_ONE, 4'h1);
    div(32'h0000_0005, 32'h0000_0000, 4'hd);
    div(32'h0000_0003, 32'h0000_0007, 4'h5);
  endtask

  // Software set and clear, then a divide without overflow-enable
  task automatic sticky_case();
    apb(1'b1, IWD_OFS_FLAGS, 32'h0000_0300);
    apb(1'b0, IWD_OFS_FLAGS, 32'h0);
    chk(got & 32'h300, 32'h300, "flags set");
    apb(1'b1, IWD_OFS_FLAGS, 32'h0);
    exp_ov = 1'b0;
    exp_so = 1'b0;
    apb(1'b0, IWD_OFS_FLAGS, 32'h0);
    chk(got & 32'h300, 32'h0, "flags clear");
    div(32'h0000_0006, 32'h0000_0003, 4'h3);
  endtask

  // Dividend write while busy must be dropped; clock enable paused
  task automatic busy_case();
    int n;
    n = done_seen;
    apb(1'b1, IWD_OFS_DIVIDEND, 32'h0000_0064);
    apb(1'b1, IWD_OFS_DIVISOR, 32'h0000_0007);
    apb(1'b1, IWD_OFS_CONTROL, 32'h0000_0003);
    apb(1'b1, IWD_OFS_DIVIDEND, 32'h0000_0001);
    apb(1'b0, IWD_OFS_CONTROL, 32'h0);
    chk(got & 32'h10, 32'h10, "busy bit");
    ce <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ce <= 1'b1;
    while (done_seen == n) @(negedge clk_sys);
    apb(1'b0, IWD_OFS_QUOTIENT, 32'h0);
    chk(got, 32'h0000_000e, "refused write");
    apb(1'b0, IWD_OFS_DIVIDEND, 32'h0);
    chk(got, 32'h0000_0064, "dividend kept");
  endtask

  // Reset in mid divide drops the result and the flags
  task automatic reset_mid_case();
    apb(1'b1, IWD_OFS_FLAGS, 32'h0000_0300);
    apb(1'b1, IWD_OFS_DIVIDEND, 32'h0000_0063);
    apb(1'b1, IWD_OFS_DIVISOR, 32'h0000_0009);
    apb(1'b1, IWD_OFS_CONTROL, 32'h0000_0009);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    exp_ov = 1'b0;
    exp_so = 1'b0;
    exp_cr = '0;
    apb(1'b0, IWD_OFS_FLAGS, 32'h0);
    chk(got, IWD_RST_WORD, "flags after reset");
    apb(1'b0, IWD_OFS_QUOTIENT, 32'h0);
    chk(got, IWD_RST_WORD, "quotient after reset");
    div(32'h0000_0063, 32'h0000_0009, 4'h9);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    reset_case();
    signed_cases();
    unsigned_cases();
    sticky_case();
    busy_case();
    reset_mid_case();
    stop_test();
  end
endmodule
`default_nettype wire
